// file: verilog/frame_limiter_pkg.sv
package frame_limiter_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] FMT_OFF = 8'h00;
  localparam logic [7:0] HEIGHT_OFF = 8'h04;
  localparam logic [7:0] WIDTH_OFF = 8'h08;
  localparam logic [7:0] EXPO_OFF = 8'h0c;
  localparam logic [7:0] BPP_OFF = 8'h10;
  localparam logic [7:0] PPF_OFF = 8'h14;
  localparam logic [7:0] PERIOD_OFF = 8'h18;
  localparam logic [7:0] STATUS_OFF = 8'h1c;
  // ----------------------------------------
  // field positions and values
  // ----------------------------------------
  localparam int MODE_POS = 8;
  localparam logic [2:0] FLEX_FORMAT = 3'h7;
  localparam logic [2:0] FLEX_MODE = 3'h0;
  // ----------------------------------------
  // reset values and limits
  // ----------------------------------------
  localparam logic [11:0] HEIGHT_RST = 12'h1e0;
  localparam logic [11:0] WIDTH_RST = 12'h0a0;
  localparam logic [19:0] EXPO_RST = 20'h003e8;
  localparam logic [13:0] BPP_MIN = 14'h0004;
  localparam logic [13:0] BPP_MAX = 14'h2000;
  localparam int BUF_DEPTH = 4096;
  localparam int FIFO_DEPTH = 8;
  // ----------------------------------------
  // times in ns and derived cycle counts
  // ----------------------------------------
  localparam longint CLK_NS = 40;
  localparam longint LINE_NS = 25210;
  localparam longint READ_FIX_NS = 1623000;
  localparam longint EXPO_OVH_NS = 94560;
  localparam longint US_NS = 1000;
  localparam longint BUS_CYCLE_NS = 125000;
  localparam int BUS_CYCLE_CYC = int'(BUS_CYCLE_NS / CLK_NS);
  localparam int DIV_STEPS = 24;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_SEND} frame_state_t;
endpackage

// file: verilog/frame_limiter.sv
// Behaviour
// - frame period is largest of three limits
// - readout period is height times line plus fixed
// - readout height comes from area height setting
// - exposure period is exposure plus overhead
// - transmit period is packets times bus cycle
// - whole frame of up to 4096 words buffered before packets sent
// - bytes per packet sets payload, 4 to 8192
// - bytes per packet resets to 8192
// - packets per frame readable, read only
// - fewer bytes per packet, more packets
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module packet_fifo #(
  parameter int W = 35,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_reg != (AW+1)'(D));
  assign out_valid_o = (cnt_reg != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rp_reg];
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_reg] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module frame_limiter (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // register port
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // frame control
  input wire logic FRAME_REQ_I,
  output logic FRAME_START_O,
  output logic [19:0] EXPO_US_O,
  // sensor words
  input wire logic SENS_VALID_I,
  input wire logic [31:0] SENS_DATA_I,
  // packet stream
  output logic PKT_VALID_O,
  input wire logic PKT_READY_I,
  output logic [31:0] PKT_DATA_O,
  output logic PKT_SOP_O,
  output logic PKT_EOP_O,
  output logic PKT_EOF_O
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [2:0] fmt_reg;
  logic [2:0] mode_reg;
  logic [11:0] height_reg;
  logic [11:0] width_reg;
  logic [19:0] expo_reg;
  logic [13:0] bpp_reg;
  logic [13:0] bpp_next;
  logic flex;
  assign flex = (fmt_reg == frame_limiter_pkg::FLEX_FORMAT) &&
                (mode_reg == frame_limiter_pkg::FLEX_MODE);
  assign EXPO_US_O = expo_reg;
  always_comb begin
    if (WDATA_I[31:14] != '0 || WDATA_I[13:0] > frame_limiter_pkg::BPP_MAX) begin
      bpp_next = frame_limiter_pkg::BPP_MAX;
    end else if (WDATA_I[13:0] < frame_limiter_pkg::BPP_MIN) begin
      bpp_next = frame_limiter_pkg::BPP_MIN;
    end else begin
      bpp_next = WDATA_I[13:0];
    end
  end
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      fmt_reg <= '0;
      mode_reg <= '0;
      height_reg <= frame_limiter_pkg::HEIGHT_RST;
      width_reg <= frame_limiter_pkg::WIDTH_RST;
      expo_reg <= frame_limiter_pkg::EXPO_RST;
      bpp_reg <= frame_limiter_pkg::BPP_MAX;
    end else if (WR_I) begin
      case (ADDR_I)
        frame_limiter_pkg::FMT_OFF: begin
          fmt_reg <= WDATA_I[2:0];
          mode_reg <= WDATA_I[frame_limiter_pkg::MODE_POS +: 3];
        end
        frame_limiter_pkg::HEIGHT_OFF: begin
          height_reg <= (WDATA_I[11:0] == '0) ? 12'h001 : WDATA_I[11:0];
        end
        frame_limiter_pkg::WIDTH_OFF: begin
          width_reg <= (WDATA_I[11:0] == '0) ? 12'h001 : WDATA_I[11:0];
        end
        frame_limiter_pkg::EXPO_OFF: expo_reg <= WDATA_I[19:0];
        frame_limiter_pkg::BPP_OFF: bpp_reg <= bpp_next;
        default: begin
        end
      endcase
    end
  end
  // ----------------------------------------
  // packets per frame divider
  // ----------------------------------------
  logic [23:0] fwords;
  logic [11:0] pwords;
  logic [23:0] num_reg;
  logic [24:0] rem_reg;
  logic [23:0] quo_reg;
  logic [4:0] step_reg;
  logic div_busy_reg;
  logic div_go_reg;
  logic [23:0] ppf_reg;
  logic [24:0] rem_sh;
  logic cfg_wr;
  assign fwords = height_reg * width_reg;
  assign pwords = bpp_reg[13:2];
  assign rem_sh = {rem_reg[23:0], num_reg[23]};
  assign cfg_wr = WR_I && (ADDR_I == frame_limiter_pkg::HEIGHT_OFF ||
                  ADDR_I == frame_limiter_pkg::WIDTH_OFF ||
                  ADDR_I == frame_limiter_pkg::BPP_OFF);
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      div_go_reg <= 1'b1;
    end else if (cfg_wr) begin
      div_go_reg <= 1'b1;
    end else begin
      div_go_reg <= 1'b0;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      num_reg <= '0;
      rem_reg <= '0;
      quo_reg <= '0;
      step_reg <= '0;
      div_busy_reg <= 1'b0;
      ppf_reg <= '0;
    end else if (div_go_reg) begin
      num_reg <= fwords + 24'(pwords) - 24'h000001;
      rem_reg <= '0;
      quo_reg <= '0;
      step_reg <= '0;
      div_busy_reg <= 1'b1;
    end else if (div_busy_reg) begin
      num_reg <= {num_reg[22:0], 1'b0};
      if (rem_sh >= 25'(pwords)) begin
        rem_reg <= rem_sh - 25'(pwords);
        quo_reg <= {quo_reg[22:0], 1'b1};
      end else begin
        rem_reg <= rem_sh;
        quo_reg <= {quo_reg[22:0], 1'b0};
      end
      step_reg <= step_reg + 5'h01;
      if (step_reg == 5'(frame_limiter_pkg::DIV_STEPS - 1)) begin
        div_busy_reg <= 1'b0;
        ppf_reg <= {quo_reg[22:0], rem_sh >= 25'(pwords)};
      end
    end
  end
  // ----------------------------------------
  // frame period limit
  // ----------------------------------------
  logic [39:0] read_ns;
  logic [39:0] expo_ns;
  logic [39:0] xmit_ns;
  logic [39:0] period_ns;
  logic [39:0] limit_reg;
  logic [39:0] elapsed_reg;
  assign read_ns = 40'(height_reg) * 40'(frame_limiter_pkg::LINE_NS) +
                   40'(frame_limiter_pkg::READ_FIX_NS);
  assign expo_ns = 40'(expo_reg) * 40'(frame_limiter_pkg::US_NS) +
                   40'(frame_limiter_pkg::EXPO_OVH_NS);
  assign xmit_ns = 40'(ppf_reg) * 40'(frame_limiter_pkg::BUS_CYCLE_NS);
  always_comb begin
    period_ns = read_ns;
    if (expo_ns > period_ns) begin
      period_ns = expo_ns;
    end
    if (xmit_ns > period_ns) begin
      period_ns = xmit_ns;
    end
  end
  // ----------------------------------------
  // frame sequencing
  // ----------------------------------------
  frame_limiter_pkg::frame_state_t state_reg;
  logic pend_reg;
  logic start;
  logic [11:0] wr_ptr_reg;
  logic [11:0] rd_ptr_reg;
  logic [23:0] in_cnt_reg;
  logic [23:0] out_cnt_reg;
  logic [23:0] fw_reg;
  logic [11:0] pw_reg;
  logic [11:0] pkt_pos_reg;
  logic pkt_on_reg;
  logic credit_reg;
  logic [11:0] bus_cnt_reg;
  logic tick;
  logic [31:0] buf_mem [frame_limiter_pkg::BUF_DEPTH];
  logic f_valid;
  logic f_ready;
  logic last_word;
  logic pkt_end;
  logic [34:0] f_out;
  assign start = pend_reg && flex && !div_busy_reg && !div_go_reg &&
                 state_reg == frame_limiter_pkg::ST_IDLE &&
                 elapsed_reg >= limit_reg;
  assign FRAME_START_O = start;
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      pend_reg <= 1'b0;
    end else if (FRAME_REQ_I) begin
      pend_reg <= 1'b1;
    end else if (start) begin
      pend_reg <= 1'b0;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      limit_reg <= '0;
      elapsed_reg <= '0;
    end else if (start) begin
      limit_reg <= period_ns;
      elapsed_reg <= '0;
    end else if (elapsed_reg < limit_reg) begin
      elapsed_reg <= elapsed_reg + 40'(frame_limiter_pkg::CLK_NS);
    end
  end
  assign tick = (bus_cnt_reg == 12'(frame_limiter_pkg::BUS_CYCLE_CYC - 1));
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      bus_cnt_reg <= '0;
    end else begin
      bus_cnt_reg <= tick ? '0 : bus_cnt_reg + 12'h001;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (SENS_VALID_I && state_reg == frame_limiter_pkg::ST_READ) begin
      buf_mem[wr_ptr_reg] <= SENS_DATA_I;
    end
  end
  assign last_word = (out_cnt_reg == fw_reg - 24'h000001);
  assign pkt_end = (pkt_pos_reg == pw_reg - 12'h001) || last_word;
  assign f_valid = pkt_on_reg;
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      state_reg <= frame_limiter_pkg::ST_IDLE;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      in_cnt_reg <= '0;
      out_cnt_reg <= '0;
      fw_reg <= '0;
      pw_reg <= '0;
      pkt_pos_reg <= '0;
      pkt_on_reg <= 1'b0;
      credit_reg <= 1'b0;
    end else begin
      case (state_reg)
        frame_limiter_pkg::ST_IDLE: begin
          credit_reg <= 1'b0;
          if (start) begin
            fw_reg <= fwords;
            pw_reg <= pwords;
            wr_ptr_reg <= '0;
            in_cnt_reg <= '0;
            state_reg <= frame_limiter_pkg::ST_READ;
          end
        end
        frame_limiter_pkg::ST_READ: begin
          if (SENS_VALID_I) begin
            if (wr_ptr_reg != 12'(frame_limiter_pkg::BUF_DEPTH - 1)) begin
              wr_ptr_reg <= wr_ptr_reg + 12'h001;
            end
            in_cnt_reg <= in_cnt_reg + 24'h000001;
            if (in_cnt_reg == fw_reg - 24'h000001) begin
              state_reg <= frame_limiter_pkg::ST_SEND;
              rd_ptr_reg <= '0;
              out_cnt_reg <= '0;
              pkt_pos_reg <= '0;
            end
          end
        end
        frame_limiter_pkg::ST_SEND: begin
          if (tick) begin
            credit_reg <= 1'b1;
          end else if (!pkt_on_reg && credit_reg) begin
            credit_reg <= 1'b0;
          end
          if (!pkt_on_reg && credit_reg) begin
            pkt_on_reg <= 1'b1;
          end else if (f_valid && f_ready) begin
            if (rd_ptr_reg != 12'(frame_limiter_pkg::BUF_DEPTH - 1)) begin
              rd_ptr_reg <= rd_ptr_reg + 12'h001;
            end
            out_cnt_reg <= out_cnt_reg + 24'h000001;
            pkt_pos_reg <= pkt_end ? '0 : pkt_pos_reg + 12'h001;
            if (pkt_end) begin
              pkt_on_reg <= 1'b0;
            end
            if (last_word) begin
              state_reg <= frame_limiter_pkg::ST_IDLE;
            end
          end
        end
        default: state_reg <= frame_limiter_pkg::ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // output buffer
  // ----------------------------------------
  packet_fifo #(
    .W(35),
    .D(frame_limiter_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .in_valid_i(f_valid),
    .in_ready_o(f_ready),
    .in_data_i({last_word, pkt_end, pkt_pos_reg == '0, buf_mem[rd_ptr_reg]}),
    .out_valid_o(PKT_VALID_O),
    .out_ready_i(PKT_READY_I),
    .out_data_o(f_out)
  );
  assign PKT_DATA_O = f_out[31:0];
  assign PKT_SOP_O = f_out[32];
  assign PKT_EOP_O = f_out[33];
  assign PKT_EOF_O = f_out[34];
  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      RDATA_O <= '0;
    end else if (RD_I) begin
      case (ADDR_I)
        frame_limiter_pkg::FMT_OFF: RDATA_O <= {21'h0, mode_reg, 5'h0, fmt_reg};
        frame_limiter_pkg::HEIGHT_OFF: RDATA_O <= {20'h0, height_reg};
        frame_limiter_pkg::WIDTH_OFF: RDATA_O <= {20'h0, width_reg};
        frame_limiter_pkg::EXPO_OFF: RDATA_O <= {12'h0, expo_reg};
        frame_limiter_pkg::BPP_OFF: RDATA_O <= {18'h0, bpp_reg};
        frame_limiter_pkg::PPF_OFF: RDATA_O <= {8'h0, ppf_reg};
        frame_limiter_pkg::PERIOD_OFF: RDATA_O <= period_ns[31:0];
        frame_limiter_pkg::STATUS_OFF: begin
          RDATA_O <= {27'h0, flex, pend_reg, div_busy_reg, state_reg};
        end
        default: RDATA_O <= '0;
      endcase
    end else begin
      RDATA_O <= '0;
    end
  end
endmodule

// file: test/frame_limiter_chk.sv
`timescale 1ns/1ns
module frame_limiter_chk (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // watched ports
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic FRAME_START_O,
  input wire logic [19:0] EXPO_US_O,
  input wire logic PKT_VALID_O,
  input wire logic PKT_READY_I,
  input wire logic [31:0] PKT_DATA_O,
  input wire logic PKT_SOP_O,
  input wire logic PKT_EOP_O,
  input wire logic PKT_EOF_O
);
  // ----------------------------------------
  // gap and length counters
  // ----------------------------------------
  logic [16:0] gap_reg;
  logic [11:0] sop_gap_reg;
  logic [13:0] len_reg;
  wire acc = PKT_VALID_O && PKT_READY_I;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) gap_reg <= '1;
    else if (FRAME_START_O) gap_reg <= 17'h1;
    else if (gap_reg != '1) gap_reg <= gap_reg + 17'h1;
  end
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) sop_gap_reg <= '1;
    else if (acc && PKT_SOP_O) sop_gap_reg <= 12'h1;
    else if (sop_gap_reg != '1) sop_gap_reg <= sop_gap_reg + 12'h1;
  end
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) len_reg <= 14'h0;
    else if (acc) len_reg <= PKT_EOP_O ? 14'h0 : len_reg + 14'h1;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  start_pulse_a: assert property (FRAME_START_O |=> !FRAME_START_O)
    else $error("frame start longer than one cycle");
  start_gap_a: assert property (FRAME_START_O |-> gap_reg >= 17'ha0f6)
    else $error("frame start before readout period");
  read_idle_a: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data without read strobe");
  pkt_hold_a: assert property (PKT_VALID_O && !PKT_READY_I |=>
    PKT_VALID_O && $stable(PKT_DATA_O) && $stable(PKT_EOF_O))
    else $error("packet word dropped while stalled");
  eof_ends_a: assert property (PKT_VALID_O && PKT_EOF_O |-> PKT_EOP_O)
    else $error("frame end inside a packet");
  expo_rst_a: assert property (disable iff (1'b0) !RST_B_I |=>
    EXPO_US_O == frame_limiter_pkg::EXPO_RST)
    else $error("exposure not at reset value");
  expo_wr_a: assert property (WR_I && ADDR_I == frame_limiter_pkg::EXPO_OFF |=>
    EXPO_US_O == $past(WDATA_I[19:0]))
    else $error("exposure write not applied");
  // fifo and stall slack of eight cycles
  pkt_gap_a: assert property (acc && PKT_SOP_O |->
    sop_gap_reg >= frame_limiter_pkg::BUS_CYCLE_CYC - 8)
    else $error("two packets in one bus cycle");
  pkt_len_a: assert property (acc && PKT_EOP_O |-> len_reg < 14'h800)
    else $error("packet payload too long");
  cover property (FRAME_START_O);
  cover property (acc && PKT_EOF_O);
  cover property (RD_I ##1 RDATA_O != 32'h0);
endmodule

bind frame_limiter frame_limiter_chk chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .FRAME_START_O(FRAME_START_O), .EXPO_US_O(EXPO_US_O), .PKT_VALID_O(PKT_VALID_O),
  .PKT_READY_I(PKT_READY_I), .PKT_DATA_O(PKT_DATA_O), .PKT_SOP_O(PKT_SOP_O),
  .PKT_EOP_O(PKT_EOP_O), .PKT_EOF_O(PKT_EOF_O));

// file: test/pkt_host.sv
`timescale 1ns/1ns
module pkt_host (
  // packet stream in
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic [31:0] data_i,
  input wire logic [2:0] flag_i,
  // back-pressure
  output logic ready_o
);
  logic [1:0] cnt;
  logic [34:0] got_q[$];
  initial begin
    cnt = 2'h0;
    ready_o = 1'b0;
  end
  // stalls one cycle in four
  always @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
    ready_o <= cnt != 2'h3;
    if (valid_i && ready_o) got_q.push_back({flag_i, data_i});
  end
endmodule

// file: test/frame_limiter_test.sv
`timescale 1ns/1ns
module frame_limiter_test;
  logic clk, rst_b, wr, rd, frame_req, sens_valid, pkt_ready, pkt_valid;
  logic frame_start, sop, eop, eof;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, sens_data, pkt_data;
  logic [19:0] expo_us;
  int n_errors, total_checks, cyc, n_starts;
  int t_start[2];
  frame_limiter uut (.CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .FRAME_REQ_I(frame_req),
    .FRAME_START_O(frame_start), .EXPO_US_O(expo_us), .SENS_VALID_I(sens_valid),
    .SENS_DATA_I(sens_data), .PKT_VALID_O(pkt_valid), .PKT_READY_I(pkt_ready),
    .PKT_DATA_O(pkt_data), .PKT_SOP_O(sop), .PKT_EOP_O(eop), .PKT_EOF_O(eof));
  pkt_host host (.clk_i(clk), .valid_i(pkt_valid), .data_i(pkt_data),
    .flag_i({sop, eop, eof}), .ready_o(pkt_ready));
  // ----------------------------------------
  // clock, timeout and start monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      finish_test();
    end
  end
  always @(negedge clk) begin
    if (frame_start === 1'b1) begin
      if (n_starts < 2) t_start[n_starts] = cyc;
      n_starts++;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  task expect_regs(input longint h, w, e, b);
    longint c, p, r;
    c = b < frame_limiter_pkg::BPP_MIN ? frame_limiter_pkg::BPP_MIN : b;
    c = c > frame_limiter_pkg::BPP_MAX ? frame_limiter_pkg::BPP_MAX : c;
    p = (h * w + (c >> 2) - 1) / (c >> 2);
    r = h * frame_limiter_pkg::LINE_NS + frame_limiter_pkg::READ_FIX_NS;
    if (e * 1000 + frame_limiter_pkg::EXPO_OVH_NS > r) r = e * 1000 + 94560;
    if (p * frame_limiter_pkg::BUS_CYCLE_NS > r) r = p * 125000;
    repeat (30) @(posedge clk);
    chk(expo_us, e[19:0]);
    rchk(frame_limiter_pkg::HEIGHT_OFF, h[31:0]);
    rchk(frame_limiter_pkg::BPP_OFF, c[31:0]);
    rchk(frame_limiter_pkg::PPF_OFF, p[31:0]);
    rchk(frame_limiter_pkg::PERIOD_OFF, r[31:0]);
  endtask
  task cfg(input longint h, w, e, b);
    wr_reg(frame_limiter_pkg::HEIGHT_OFF, h[31:0]);
    wr_reg(frame_limiter_pkg::WIDTH_OFF, w[31:0]);
    wr_reg(frame_limiter_pkg::EXPO_OFF, e[31:0]);
    wr_reg(frame_limiter_pkg::BPP_OFF, b[31:0]);
    expect_regs(h, w, e, b);
  endtask
  task pulse;
    @(posedge clk);
    frame_req <= 1'b1;
    @(posedge clk);
    frame_req <= 1'b0;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_b, wr, rd, frame_req, sens_valid} = 5'h0;
    addr = 8'h0;
    wdata = 32'h0;
    sens_data = 32'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    expect_regs(frame_limiter_pkg::HEIGHT_RST, frame_limiter_pkg::WIDTH_RST,
      frame_limiter_pkg::EXPO_RST, frame_limiter_pkg::BPP_MAX);
    rchk(8'h40, 32'h0);
    rchk(frame_limiter_pkg::STATUS_OFF, 32'h0);
    cfg(64'h1, 64'h1, 64'hdbba0, 64'h2000);
    cfg(64'h64, 64'h64, 64'ha, 64'h2);
    cfg(64'h64, 64'h64, 64'ha, 64'h3e8);
    cfg(64'h2, 64'h1, 64'ha, 64'h2328);
    cfg(64'h1, 64'h8, 64'ha, 64'h10);
    wr_reg(frame_limiter_pkg::HEIGHT_OFF, 32'h0);
    rchk(frame_limiter_pkg::HEIGHT_OFF, 32'h1);
    wr_reg(frame_limiter_pkg::PPF_OFF, 32'h5);
    rchk(frame_limiter_pkg::PPF_OFF, 32'h2);
    pulse();
    repeat (50) @(posedge clk);
    chk(n_starts, 0);
    wr_reg(frame_limiter_pkg::FMT_OFF, 32'h7);
    for (int i = 0; i < 100 && n_starts == 0; i++) @(posedge clk);
    chk(n_starts, 1);
    rchk(frame_limiter_pkg::FMT_OFF, 32'h7);
    rchk(frame_limiter_pkg::STATUS_OFF, 32'h11);
    pulse();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      sens_valid <= 1'b1;
      sens_data <= 32'ha0 + i;
      @(negedge clk);
      chk(pkt_valid, 1'b0);
    end
    @(posedge clk);
    sens_valid <= 1'b0;
    for (int i = 0; i < 9000 && host.got_q.size() < 8; i++) @(posedge clk);
    chk(host.got_q.size(), 8);
    for (int i = 0; i < 8; i++) begin
      chk(host.got_q[i], {i % 4 == 0, i % 4 == 3, i == 7, 32'ha0 + i});
    end
    for (int i = 0; i < 45000 && n_starts < 2; i++) @(posedge clk);
    // start rises in the cycle the elapsed count reaches the limit; the count is cleared one edge after start
    chk(t_start[1] - t_start[0], (1648210 + 39) / 40 + 1);
    finish_test();
  end
endmodule
